// file: shared/fes_consts.svh
// Constants for the flash erase/suspend host sequencer
// Behaviour
// - Chip erase needs six cycles AA,55,80,AA,55,10
// - Word addresses 555/2AA; byte mode AAA/555
// - Host polls data-poll bit for completion
// - Reset aborts erase; host reissues sequence
// - Erase suspend B0 only in sector erase
// - Erase resume is 30 at sector address
// - Program resume is 30, any address
`ifndef FES_CONSTS_SVH
`define FES_CONSTS_SVH
`define FES_D_UNLOCK1    16'h00aa
`define FES_D_UNLOCK2    16'h0055
`define FES_D_SETUP      16'h0080
`define FES_D_CHIP       16'h0010
`define FES_D_SUSPEND    16'h00b0
`define FES_D_RESUME     16'h0030
`define FES_D_ERASED     16'hffff
`define FES_W_ADDR_A     12'h555
`define FES_W_ADDR_B     12'h2aa
`define FES_B_ADDR_A     12'haaa
`define FES_B_ADDR_B     12'h555
`define FES_POLL_BIT     7
`define FES_ERS_SUSP_NS  20000
`define FES_PGM_SUSP_NS  15000
`define FES_CLK_NS       10
`define FES_STROBE_CYC   4
`define FES_WAIT_CYC     2
`endif

// file: shared/fes_pkg.sv
// Types for the flash erase/suspend host sequencer
package fes_pkg;
	// Host command codes
	typedef enum logic [2:0] {
		FES_CMD_CHIP_ERASE,
		FES_CMD_ERS_SUSPEND,
		FES_CMD_ERS_RESUME,
		FES_CMD_PGM_SUSPEND,
		FES_CMD_PGM_RESUME,
		FES_CMD_POLL
	} fes_cmd_e;
	// One bus cycle request to the pin engine
	typedef struct packed {
		logic        rd;
		logic [11:0] addr;
		logic [15:0] data;
	} fes_cyc_s;
endpackage : fes_pkg

// file: shared/fes_bus_if.sv
// Handshake between sequencer and pin cycle engine
`timescale 1ns/1ps
`default_nettype none
interface fes_bus_if;
	fes_pkg::fes_cyc_s cyc;     // Requested cycle
	logic              req;     // Cycle request pulse
	logic              done;    // Cycle finished pulse
	logic [15:0]       rdata;   // Data of a read cycle
	modport seq (output cyc, output req, input done, input rdata);
	modport eng (input cyc, input req, output done, output rdata);
endinterface : fes_bus_if
`default_nettype wire

// file: src/fes_pin_engine.sv
// Pin-level write and read cycle engine for the flash bus
`timescale 1ns/1ps
`default_nettype none
`include "fes_consts.svh"
module fes_pin_engine (
	input  wire logic   clk,
	input  wire logic   rst,
	fes_bus_if.eng      bus,
	input  wire logic   dq_sync,
	input  wire logic [15:0] dq_in,
	output logic        ce_n_r,
	output logic        we_n_r,
	output logic        oe_n_r,
	output logic        dq_oe_r,
	output logic [11:0] addr_r,
	output logic [15:0] dq_out_r
);
	typedef enum logic [1:0] {FES_E_IDLE, FES_E_LOW, FES_E_HIGH} fes_eng_e;
	fes_eng_e    st_r, st_nxt;          // Engine state
	logic [3:0]  cnt_r, cnt_nxt;        // Phase counter
	logic        rd_r, rd_nxt;          // Cycle is a read
	logic        ce_nxt, we_nxt, oe_nxt, doe_nxt;
	logic [11:0] a_nxt;
	logic [15:0] d_nxt, rdat_r, rdat_nxt;
	logic        done_r, done_nxt;
	assign bus.done  = done_r;
	assign bus.rdata = rdat_r;
	// Next-state: strobe low phase, then high recovery phase
	always_comb begin
		st_nxt = st_r; cnt_nxt = cnt_r; rd_nxt = rd_r;
		ce_nxt = ce_n_r; we_nxt = we_n_r; oe_nxt = oe_n_r;
		doe_nxt = dq_oe_r; a_nxt = addr_r; d_nxt = dq_out_r;
		rdat_nxt = rdat_r; done_nxt = 1'b0;
		case (st_r)
			FES_E_IDLE: if (bus.req) begin
				st_nxt = FES_E_LOW; cnt_nxt = 4'h0; rd_nxt = bus.cyc.rd;
				a_nxt = bus.cyc.addr; d_nxt = bus.cyc.data;
				ce_nxt = 1'b0; doe_nxt = !bus.cyc.rd;
				we_nxt = bus.cyc.rd; oe_nxt = !bus.cyc.rd;
			end
			FES_E_LOW: begin
				cnt_nxt = cnt_r + 4'h1;
				if (cnt_r == 4'(`FES_STROBE_CYC - 1)) begin
					// Device latches on this rising strobe edge
					we_nxt = 1'b1; oe_nxt = 1'b1;
					st_nxt = FES_E_HIGH; cnt_nxt = 4'h0;
				end
			end
			default: begin
				// Data held one phase past the rising edge for hold time
				cnt_nxt = cnt_r + 4'h1;
				// Sampler lags the pins by four edges, so take read data
				// one cycle after the strobe rises, not at the rise itself
				if (rd_r && cnt_r == 4'h0) rdat_nxt = dq_in;
				if (cnt_r == 4'(`FES_STROBE_CYC - 1)) begin
					ce_nxt = 1'b1; doe_nxt = 1'b0;
					st_nxt = FES_E_IDLE; done_nxt = 1'b1;
				end
			end
		endcase
	end
	// Register stage
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= FES_E_IDLE; cnt_r <= 4'h0; rd_r <= 1'b0;
			ce_n_r <= 1'b1; we_n_r <= 1'b1; oe_n_r <= 1'b1;
			dq_oe_r <= 1'b0; addr_r <= 12'h000; dq_out_r <= 16'h0000;
			rdat_r <= 16'h0000; done_r <= 1'b0;
		end else begin
			st_r <= st_nxt; cnt_r <= cnt_nxt; rd_r <= rd_nxt;
			ce_n_r <= ce_nxt; we_n_r <= we_nxt; oe_n_r <= oe_nxt;
			dq_oe_r <= doe_nxt; addr_r <= a_nxt; dq_out_r <= d_nxt;
			rdat_r <= rdat_nxt; done_r <= done_nxt;
		end
	end
	// Strobes never both low
	strobe_excl_a: assert property (@(posedge clk) disable iff (rst)
		!(!we_n_r && !oe_n_r)) else $error("write and read strobes overlap");
	// Address stable while write strobe low
	addr_hold_a: assert property (@(posedge clk) disable iff (rst)
		(!we_n_r && $past(!we_n_r)) |-> $stable(addr_r))
		else $error("address moved during write strobe");
	// Write strobe low exactly the set phase
	we_width_a: assert property (@(posedge clk) disable iff (rst)
		$fell(we_n_r) |-> !we_n_r [*4] ##1 we_n_r)
		else $error("write strobe width wrong");
	wr_cycle_c: cover property (@(posedge clk) disable iff (rst) $rose(we_n_r));
	// Finished pulse lasts one cycle only
	done_pulse_a: assert property (@(posedge clk) disable iff (rst)
		done_r |=> !done_r) else $error("cycle done pulse too long");
	rd_settle_c: cover property (@(posedge clk) disable iff (rst)
		rd_r && st_r == FES_E_HIGH && dq_sync);
endmodule : fes_pin_engine
`default_nettype wire

// file: src/fes_host_seq.sv
// Host sequencer: chip erase, erase and program suspend/resume
`timescale 1ns/1ps
`default_nettype none
`include "fes_consts.svh"
module fes_host_seq #(
	parameter int CLK_NS = `FES_CLK_NS
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	input  wire logic        CMD_VALID,
	input  wire logic [2:0]  CMD_CODE,
	input  wire logic [11:0] CMD_SECTOR,
	input  wire logic        BYTE_MODE,
	input  wire logic        ERASE_IS_SECTOR,
	input  wire logic        PGM_ACTIVE,
	input  wire logic [15:0] FL_DQ_I,
	output logic [15:0]      FL_DQ_O,
	output logic             FL_DQ_OE,
	output logic [11:0]      FL_ADDR,
	output logic             FL_CE_N,
	output logic             FL_WE_N,
	output logic             FL_OE_N,
	output logic             CMD_READY,
	output logic             CMD_DONE,
	output logic             CMD_REJECT,
	output logic             ERASE_BUSY,
	output logic             ERS_SUSPENDED,
	output logic             PGM_SUSPENDED,
	output logic             TIMEOUT
);
	// Suspend deadlines in cycles, longest time so rounded down
	localparam int ERS_CYC = `FES_ERS_SUSP_NS / CLK_NS;
	localparam int PGM_CYC = `FES_PGM_SUSP_NS / CLK_NS;
	typedef enum logic [2:0] {
		FES_S_IDLE, FES_S_WRITE, FES_S_WAIT, FES_S_POLL, FES_S_CHECK
	} fes_st_e;
	fes_bus_if bus ();
	// Three-stage sampler on the data pins
	logic [15:0] dq_s1_r, dq_s2_r, dq_s3_r, dq_stable_r;
	fes_st_e     st_r, st_nxt;
	logic [2:0]  idx_r, idx_nxt;       // Cycle index in sequence
	logic [2:0]  len_r, len_nxt;       // Sequence length
	logic [2:0]  op_r, op_nxt;         // Running command
	logic [11:0] sec_r, sec_nxt;       // Sector address
	logic        byte_r, byte_nxt;     // Byte addressing
	logic [15:0] tmr_r, tmr_nxt;       // Deadline counter
	logic        req_r, req_nxt;
	logic        busy_r, busy_nxt, es_r, es_nxt, ps_r, ps_nxt;
	logic        done_r, done_nxt, rej_r, rej_nxt, to_r, to_nxt;
	fes_pkg::fes_cyc_s cyc_r, cyc_nxt;
	logic [11:0] a_nxt;
	logic [15:0] d_nxt;
	logic        dq_agree;         // Sampler stages two and three match
	assign bus.req = req_r;
	assign bus.cyc = cyc_r;
	assign dq_agree = (dq_s2_r == dq_s3_r);
	// Sampler: change accepted once stages two and three agree
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dq_s1_r <= 16'h0000; dq_s2_r <= 16'h0000;
			dq_s3_r <= 16'h0000; dq_stable_r <= 16'h0000;
		end else begin
			dq_s1_r <= FL_DQ_I; dq_s2_r <= dq_s1_r; dq_s3_r <= dq_s2_r;
			if (dq_s2_r == dq_s3_r) dq_stable_r <= dq_s3_r;
		end
	end
	// Cycle address/data for the current step of the sequence
	always_comb begin
		a_nxt = sec_r;
		d_nxt = `FES_D_RESUME;
		case (op_r)
			3'(fes_pkg::FES_CMD_CHIP_ERASE): begin
				// Steps 1 and 4 use the second unlock address
				if (idx_r == 3'h1 || idx_r == 3'h4)
					a_nxt = byte_r ? `FES_B_ADDR_B : `FES_W_ADDR_B;
				else
					a_nxt = byte_r ? `FES_B_ADDR_A : `FES_W_ADDR_A;
				// Six data words in fixed order
				if (idx_r == 3'h0 || idx_r == 3'h3) d_nxt = `FES_D_UNLOCK1;
				else if (idx_r == 3'h1 || idx_r == 3'h4) d_nxt = `FES_D_UNLOCK2;
				else if (idx_r == 3'h2) d_nxt = `FES_D_SETUP;
				else d_nxt = `FES_D_CHIP;
			end
			3'(fes_pkg::FES_CMD_ERS_SUSPEND): d_nxt = `FES_D_SUSPEND;
			3'(fes_pkg::FES_CMD_PGM_SUSPEND): d_nxt = `FES_D_SUSPEND;
			default: d_nxt = `FES_D_RESUME;
		endcase
	end
	// Main sequencing
	always_comb begin
		st_nxt = st_r; idx_nxt = idx_r; len_nxt = len_r; op_nxt = op_r;
		sec_nxt = sec_r; byte_nxt = byte_r; tmr_nxt = tmr_r;
		req_nxt = 1'b0; cyc_nxt = cyc_r;
		busy_nxt = busy_r; es_nxt = es_r; ps_nxt = ps_r;
		done_nxt = 1'b0; rej_nxt = 1'b0; to_nxt = 1'b0;
		// Deadline watch first, so a fresh suspend reloads it below
		if (tmr_r != 16'h0000) begin
			tmr_nxt = tmr_r - 16'h0001;
			if (tmr_r == 16'h0001) to_nxt = 1'b1;
		end
		case (st_r)
			FES_S_IDLE: if (CMD_VALID) begin
				op_nxt = CMD_CODE; sec_nxt = CMD_SECTOR; byte_nxt = BYTE_MODE;
				idx_nxt = 3'h0; len_nxt = 3'h1; st_nxt = FES_S_WRITE;
				case (CMD_CODE)
					3'(fes_pkg::FES_CMD_CHIP_ERASE): begin
						// No second chip erase while erasing or erase-suspended
						if (busy_r || es_r) begin
							rej_nxt = 1'b1; st_nxt = FES_S_IDLE;
						end else len_nxt = 3'h6;
					end
					3'(fes_pkg::FES_CMD_ERS_SUSPEND):
						// Chip erase cannot be suspended
						if (!busy_r || !ERASE_IS_SECTOR || es_r) begin
							rej_nxt = 1'b1; st_nxt = FES_S_IDLE;
						end
					3'(fes_pkg::FES_CMD_ERS_RESUME):
						// Extra resumes are pointless
						if (!es_r || ps_r) begin
							rej_nxt = 1'b1; st_nxt = FES_S_IDLE;
						end
					3'(fes_pkg::FES_CMD_PGM_SUSPEND):
						// Legal also inside an erase suspend
						if (!PGM_ACTIVE || ps_r) begin
							rej_nxt = 1'b1; st_nxt = FES_S_IDLE;
						end
					3'(fes_pkg::FES_CMD_PGM_RESUME):
						if (!ps_r) begin
							rej_nxt = 1'b1; st_nxt = FES_S_IDLE;
						end
					default: if (!busy_r) begin
						rej_nxt = 1'b1; st_nxt = FES_S_IDLE;
					end else st_nxt = FES_S_POLL;
				endcase
			end
			FES_S_WRITE: begin
				req_nxt = 1'b1;
				cyc_nxt.rd = 1'b0; cyc_nxt.addr = a_nxt; cyc_nxt.data = d_nxt;
				st_nxt = FES_S_WAIT;
			end
			FES_S_WAIT: if (bus.done) begin
				if (cyc_r.rd) st_nxt = FES_S_CHECK;
				else if (idx_r + 3'h1 < len_r) begin
					idx_nxt = idx_r + 3'h1; st_nxt = FES_S_WRITE;
				end else begin
					st_nxt = FES_S_IDLE; done_nxt = 1'b1;
					case (op_r)
						3'(fes_pkg::FES_CMD_CHIP_ERASE): busy_nxt = 1'b1;
						3'(fes_pkg::FES_CMD_ERS_SUSPEND): begin
							es_nxt = 1'b1; tmr_nxt = 16'(ERS_CYC);
						end
						3'(fes_pkg::FES_CMD_ERS_RESUME): es_nxt = 1'b0;
						3'(fes_pkg::FES_CMD_PGM_SUSPEND): begin
							ps_nxt = 1'b1; tmr_nxt = 16'(PGM_CYC);
						end
						default: ps_nxt = 1'b0;
					endcase
				end
			end
			FES_S_POLL: begin
				// Status read at the sector under erase
				req_nxt = 1'b1;
				cyc_nxt.rd = 1'b1; cyc_nxt.addr = sec_r; cyc_nxt.data = 16'h0000;
				st_nxt = FES_S_WAIT;
			end
			default: begin
				// Data-poll bit high means erase over
				if (bus.rdata[`FES_POLL_BIT]) busy_nxt = 1'b0;
				st_nxt = FES_S_IDLE; done_nxt = 1'b1;
			end
		endcase
	end
	// Register stage
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			// Reset forgets the erase; host must reissue it
			st_r <= FES_S_IDLE; idx_r <= 3'h0; len_r <= 3'h0; op_r <= 3'h0;
			sec_r <= 12'h000; byte_r <= 1'b0; tmr_r <= 16'h0000;
			req_r <= 1'b0; cyc_r <= '0; busy_r <= 1'b0; es_r <= 1'b0;
			ps_r <= 1'b0; done_r <= 1'b0; rej_r <= 1'b0; to_r <= 1'b0;
		end else begin
			st_r <= st_nxt; idx_r <= idx_nxt; len_r <= len_nxt; op_r <= op_nxt;
			sec_r <= sec_nxt; byte_r <= byte_nxt; tmr_r <= tmr_nxt;
			req_r <= req_nxt; cyc_r <= cyc_nxt; busy_r <= busy_nxt;
			es_r <= es_nxt; ps_r <= ps_nxt; done_r <= done_nxt;
			rej_r <= rej_nxt; to_r <= to_nxt;
		end
	end
	// Status outputs, all registered
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			CMD_READY <= 1'b0; CMD_DONE <= 1'b0; CMD_REJECT <= 1'b0;
			ERASE_BUSY <= 1'b0; ERS_SUSPENDED <= 1'b0;
			PGM_SUSPENDED <= 1'b0; TIMEOUT <= 1'b0;
		end else begin
			CMD_READY <= (st_nxt == FES_S_IDLE);
			CMD_DONE <= done_nxt; CMD_REJECT <= rej_nxt;
			ERASE_BUSY <= busy_nxt; ERS_SUSPENDED <= es_nxt;
			PGM_SUSPENDED <= ps_nxt; TIMEOUT <= to_nxt;
		end
	end
	fes_pin_engine u_eng (
		.clk      (CLK_SYS),
		.rst      (RST),
		.bus      (bus.eng),
		.dq_sync  (dq_agree),
		.dq_in    (dq_stable_r),
		.ce_n_r   (FL_CE_N),
		.we_n_r   (FL_WE_N),
		.oe_n_r   (FL_OE_N),
		.dq_oe_r  (FL_DQ_OE),
		.addr_r   (FL_ADDR),
		.dq_out_r (FL_DQ_O)
	);
	// Chip erase ends on the erase command data
	chip_last_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_r == FES_S_WAIT && bus.done && op_r == 3'h0 && idx_r == 3'h5)
		|-> cyc_r.data == `FES_D_CHIP) else $error("bad last erase word");
	chip_addr_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(req_r && op_r == 3'h0 && !byte_r && idx_r == 3'h1)
		|-> cyc_r.addr == `FES_W_ADDR_B) else $error("bad unlock address");
	no_cmd_busy_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_r == FES_S_IDLE && CMD_VALID && busy_r && CMD_CODE == 3'h0)
		|=> rej_r) else $error("command sent during erase");
	susp_chip_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_r == FES_S_IDLE && CMD_VALID && CMD_CODE == 3'h1 && !ERASE_IS_SECTOR)
		|=> rej_r) else $error("suspend sent in chip erase");
	resume_twice_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_r == FES_S_IDLE && CMD_VALID && CMD_CODE == 3'h2 && !es_r)
		|=> rej_r ##1 !es_r) else $error("resume without suspend");
	susp_data_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(req_r && !cyc_r.rd && (op_r == 3'h1 || op_r == 3'h3))
		|-> cyc_r.data == `FES_D_SUSPEND) else $error("bad suspend word");
	pgm_res_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		$fell(ps_r) |-> op_r == 3'h4) else $error("program resume lost");
	poll_done_a: assert property (@(posedge CLK_SYS) disable iff (RST)
		(st_r == FES_S_CHECK && bus.rdata[`FES_POLL_BIT]) |=> !busy_r)
		else $error("erase end missed");
	chip_c: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(busy_r));
	esusp_c: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(es_r));
	psusp_c: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(ps_r));
endmodule : fes_host_seq
`default_nettype wire

// file: bench/fes_flash_model.sv
// Behavioural flash device that answers the host sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fes_consts.svh"
module fes_flash_model #(
	parameter int ERASE_NS = 3000
) (
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        byte_mode,
	input  wire logic        sect_kind,
	input  wire logic [11:0] addr,
	input  wire logic [15:0] din,
	output logic [15:0]      dout
);
	int          step = 0;        // Unlock cycles matched so far
	logic        ers = 1'b0;      // Erase running
	logic        done_e = 1'b0;   // Array has been erased
	logic        susp = 1'b0;     // Erase or program suspended
	logic        tog = 1'b0;      // Toggle bit state
	logic [15:0] last = 16'h0000; // Last word driven
	logic [15:0] drv;             // Word shown on a read
	logic [11:0] a_hi;            // First unlock address
	logic [11:0] a_lo;            // Second unlock address

	// Data expected in each unlock cycle
	function automatic logic [15:0] cyc_d(input int s);
		case (s)
			1, 4: return `FES_D_UNLOCK2;
			2: return `FES_D_SETUP;
			5: return `FES_D_CHIP;
			default: return `FES_D_UNLOCK1;
		endcase
	endfunction : cyc_d

	assign a_hi = byte_mode ? `FES_B_ADDR_A : `FES_W_ADDR_A;
	assign a_lo = byte_mode ? `FES_B_ADDR_B : `FES_W_ADDR_B;

	// Cycle taken on strobe rise with chip enabled
	always @(posedge we_n) if (!ce_n) begin
		// Chip erase cannot be suspended
		// Program suspend works inside an erase suspend too
		if (din == `FES_D_SUSPEND && (!ers || sect_kind)) susp = 1'b1;
		// Resumed work shows its progress on status again
		else if (din == `FES_D_RESUME && susp) susp = 1'b0;
		else if (ers) step = 0; // Ignored while erasing
		else if (addr == ((step == 1 || step == 4) ? a_lo : a_hi)
				&& din == cyc_d(step)) begin
			step++;
			if (step == 6) begin
				step = 0;
				ers = 1'b1; // Timed from this strobe rise
			end
		end else step = 0; // Wrong cycle abandons the sequence
	end

	// Erase runs alone, held at its end until not suspended
	always @(posedge ers) begin
		#(ERASE_NS);
		wait (!susp);
		ers = 1'b0;
		done_e = 1'b1;
	end

	// Toggle flips on each read while actively erasing
	always @(negedge oe_n) if (ers && !susp) tog = ~tog;

	// Status while erasing, all ones after
	assign drv = ers ? {8'h00, susp, tog, 6'h00}
		: (done_e ? `FES_D_ERASED : 16'h5a3c);
	always @(posedge oe_n) last = drv;
	// Released bus shows the inverse, never a stale word
	assign dout = (!ce_n && !oe_n) ? drv : ~last;
endmodule : fes_flash_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the host erase/suspend sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fes_consts.svh"
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin \
	failures++; $display("FAIL %0t %s", $time, m); end end
module testbench;
	localparam logic [1:0] DN = 2'b10; // Command completed
	localparam logic [1:0] RJ = 2'b01; // Command refused
	// Suspend deadlines in cycles
	localparam logic [15:0] ERS_T = 16'(`FES_ERS_SUSP_NS / `FES_CLK_NS);
	localparam logic [15:0] PGM_T = 16'(`FES_PGM_SUSP_NS / `FES_CLK_NS);
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic byte_mode = 1'b0;
	logic ers_sect = 1'b0;
	logic pgm_active = 1'b0;
	logic prev_we = 1'b1;
	logic [2:0] code = 3'h0;
	logic [11:0] sect = 12'h000;
	logic [15:0] dq_o, dq_i, dev_q;
	logic [11:0] fl_a;
	logic dq_oe, ce_n, we_n, oe_n, cmd_ready, cmd_done, cmd_reject;
	logic ers_busy, ers_susp, pgm_susp;
	logic tmo;                   // Suspend deadline pulse
	logic [15:0] tmo_n = 16'h0000; // Deadline due for the next command
	int tmo_left = 0;            // Cycles until the deadline pulse
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [17:0] res_q [$]; // Expected deadline and result kind
	logic [28:0] bus_q [$]; // Expected writes: check-address, addr, data

	always #5 clk = ~clk;
	// Host drives the bus while enabled, else the device
	assign dq_i = dq_oe ? dq_o : dev_q;

	fes_host_seq #(.CLK_NS(10)) dut (.CLK_SYS(clk), .RST(rst),
		.CMD_VALID(cmd_valid), .CMD_CODE(code), .CMD_SECTOR(sect),
		.BYTE_MODE(byte_mode), .ERASE_IS_SECTOR(ers_sect),
		.PGM_ACTIVE(pgm_active), .FL_DQ_I(dq_i), .FL_DQ_O(dq_o),
		.FL_DQ_OE(dq_oe), .FL_ADDR(fl_a), .FL_CE_N(ce_n), .FL_WE_N(we_n),
		.FL_OE_N(oe_n), .CMD_READY(cmd_ready), .CMD_DONE(cmd_done),
		.CMD_REJECT(cmd_reject), .ERASE_BUSY(ers_busy),
		.ERS_SUSPENDED(ers_susp), .PGM_SUSPENDED(pgm_susp), .TIMEOUT(tmo));
	fes_flash_model #(.ERASE_NS(3000)) flash (.ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .byte_mode(byte_mode), .sect_kind(ers_sect),
		.addr(fl_a), .din(dq_o), .dout(dev_q));

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			test_done();
		end
	end

	// One command: hold valid until taken, then wait for its answer
	task automatic cmd(input logic [2:0] c, input logic [1:0] r);
		int n;
		res_q.push_back({tmo_n, r});
		tmo_n = 16'h0000;
		code = c;
		cmd_valid = 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 200);
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (cmd_done !== 1'b1 && cmd_reject !== 1'b1 && n < 2500) begin
			@(posedge clk);
			n++;
		end
		`CHK(n < 2500, 1'b1, "no answer")
		@(negedge clk);
	endtask : cmd

	task automatic bus(input logic ca, input logic [11:0] a,
		input logic [15:0] d);
		bus_q.push_back({ca, a, d});
	endtask : bus

	// Six-write chip erase in the current addressing mode
	task automatic erase_seq;
		logic [11:0] hi, lo;
		hi = byte_mode ? `FES_B_ADDR_A : `FES_W_ADDR_A;
		lo = byte_mode ? `FES_B_ADDR_B : `FES_W_ADDR_B;
		bus(1'b1, hi, `FES_D_UNLOCK1);
		bus(1'b1, lo, `FES_D_UNLOCK2);
		bus(1'b1, hi, `FES_D_SETUP);
		bus(1'b1, hi, `FES_D_UNLOCK1);
		bus(1'b1, lo, `FES_D_UNLOCK2);
		bus(1'b1, hi, `FES_D_CHIP);
		cmd(3'h0, DN);
	endtask : erase_seq

	// Poll until the data-poll bit reports the erase finished
	task automatic poll_wait;
		int n;
		n = 0;
		while (ers_busy === 1'b1 && n < 100) begin
			cmd(3'h5, DN);
			n++;
		end
		`CHK(ers_busy, 1'b0, "erase not finished")
	endtask : poll_wait

	// Suspend, resume, repeated resume, twice over
	task automatic sr(input logic sel);
		logic [2:0] s;
		s = sel ? 3'h3 : 3'h1;
		repeat (2) begin
			bus(!sel, sect, `FES_D_SUSPEND);
			tmo_n = sel ? PGM_T : ERS_T;
			cmd(s, DN);
			`CHK(sel ? pgm_susp : ers_susp, 1'b1, "not suspended")
			if (!sel) begin
				cmd(s, RJ);
				// Program suspend nested in the erase suspend
				pgm_active = 1'b1;
				bus(1'b0, sect, `FES_D_SUSPEND);
				tmo_n = PGM_T;
				cmd(3'h3, DN);
				`CHK(pgm_susp, 1'b1, "nested suspend lost")
				cmd(3'h2, RJ);
				bus(1'b0, sect, `FES_D_RESUME);
				cmd(3'h4, DN);
				pgm_active = 1'b0;
			end
			bus(!sel, sect, `FES_D_RESUME);
			cmd(s + 3'h1, DN);
			`CHK(sel ? pgm_susp : ers_susp, 1'b0, "still suspended")
			cmd(s + 3'h1, RJ);
		end
	endtask : sr

	// Watcher: each answer and each write strobe rise takes the oldest note
	always @(posedge clk) begin : watch
		logic [28:0] e;
		logic hit;
		// Deadline pulse exactly when the last suspend's count runs out
		hit = (tmo_left == 1);
		if (tmo_left != 0) tmo_left--;
		if (rst === 1'b0) `CHK(tmo, hit, "deadline pulse")
		if (cmd_done === 1'b1 || cmd_reject === 1'b1) begin
			`CHK(res_q.size() != 0, 1'b1, "extra answer")
			if (res_q.size() != 0) begin
				e[17:0] = res_q.pop_front();
				`CHK({cmd_done, cmd_reject}, e[1:0], "answer kind")
				if (e[17:2] != 16'h0000) tmo_left = int'(e[17:2]);
			end
		end
		if (prev_we === 1'b0 && we_n === 1'b1 && ce_n === 1'b0) begin
			`CHK(bus_q.size() != 0, 1'b1, "extra write")
			if (bus_q.size() != 0) begin
				e = bus_q.pop_front();
				`CHK(dq_o, e[15:0], "write data")
				if (e[28]) `CHK(fl_a, e[27:16], "write address")
			end
		end
		prev_we = we_n;
	end

	// Main sequence, inputs moved on falling edges
	initial begin
		void'($urandom(32'h84264034));
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(cmd_ready, 1'b1, "not ready after reset")
		`CHK({ers_busy, ers_susp, pgm_susp}, 3'h0, "flags after reset")
		for (int c = 1; c < 6; c++) cmd(c[2:0], RJ);
		erase_seq();
		`CHK(ers_busy, 1'b1, "erase not busy")
		cmd(3'h0, RJ);
		cmd(3'h1, RJ);
		poll_wait();
		byte_mode = 1'b1;
		erase_seq();
		poll_wait();
		byte_mode = 1'b0;
		erase_seq();
		ers_sect = 1'b1;
		sect = 12'($urandom());
		sr(1'b0);
		poll_wait();
		ers_sect = 1'b0;
		pgm_active = 1'b1;
		sect = 12'($urandom());
		sr(1'b1);
		pgm_active = 1'b0;
		// Let the last suspend deadline run out and be checked
		wait (tmo_left == 0);
		@(negedge clk);
		// Reset in mid-erase, then the full sequence again
		erase_seq();
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(ers_busy, 1'b0, "erase state kept")
		erase_seq();
		poll_wait();
		`CHK(res_q.size() + bus_q.size(), 0, "notes left over")
		test_done();
	end
endmodule : testbench
`default_nettype wire
